// >>> logic/nsp_ctrl.v
// Overview of operation
// - Flash holds 8192 words of 14 bits
// - Flash rows are 32 words, erase unit
// - Erase sets ones, flash and ID programming only clears; EEPROM bytes are overwritten
// - Row data goes through hidden write latches
// - EEPROM 256 bytes, written byte by byte
// - Pointer high 0x70 selects EEPROM bytes
// - Pointer read stalls, returns one word
// - Pointer path never writes or erases
// - Region select picks flash or config space
// - Read strobe stalls, loads data, self-clears
// - Data pair holds until read or write
// - Code protect blocks register access
// - User ID and config words program and erase
// - Key 55h, AAh, then write strobe
// - Write and erase only after full unlock
// - Write strobe stalls CPU until done
// - Internal timer paces program and erase
// - Write protect field blocks flash self-write
// - Code protect also blocks self-write
// - No bulk erase from self-programming
// - Completion clears strobe, sets done flag
// - Latches return to blank after programming
// - Protected erase clears strobe, skips
// - Latch-only select loads one latch
`timescale 1ns/1ps
`default_nettype none
`include "nsp_map.vh"
module nsp_ctrl #(
  parameter PROG_CYC = `NSP_PROG_CYC
) (
  input  wire        I_REF_CLK,
  input  wire        I_RESET,
  input  wire        I_WB_CYC,
  input  wire        I_WB_STB,
  input  wire        I_WB_WE,
  input  wire [7:0]  I_WB_ADR,
  input  wire [3:0]  I_WB_SEL,
  input  wire [31:0] I_WB_DAT,
  output reg  [31:0] O_WB_DAT,
  output wire        O_WB_ACK,
  output wire        O_CPU_STALL,
  output wire        O_DONE_IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // States
  localparam ST_IDLE = 4'b0001;
  localparam ST_READ = 4'b0010;
  localparam ST_PROG = 4'b0100;
  localparam ST_IND  = 4'b1000;
  localparam UK_IDLE = 3'b001;
  localparam UK_ONE  = 3'b010;
  localparam UK_TWO  = 3'b100;

  // Storage: flash, user IDs + config, EEPROM, latches
  reg [13:0] flash_q [0:`NSP_FLASH_WORDS-1];
  reg [13:0] uid_q   [0:`NSP_UID_WORDS-1];
  reg [7:0]  ee_q    [0:255];
  reg [13:0] latch_q [0:`NSP_ROW_WORDS-1];

  reg [3:0]  st_q;
  reg [2:0]  uk_q;
  reg [7:0]  ctrl_q;
  reg [7:0]  adrl_q;
  reg [6:0]  adrh_q;
  reg [7:0]  datl_q;
  reg [5:0]  dath_q;
  reg [3:0]  cfg_q;
  reg [7:0]  ptrl_q;
  reg [7:0]  ptrh_q;
  reg [13:0] indirect_access_port_q;
  reg [15:0] tmr_q;
  reg        ack_q;
  reg        ind_rd_q;
  reg [2:0]  uk_d;
  reg [31:0] rd_mux;
  integer    k;

  wire [14:0] adr  = {adrh_q, adrl_q};
  wire [13:0] dat  = {dath_q, datl_q};
  wire        regs = ctrl_q[`NSP_B_REGS];
  wire        cp   = cfg_q[`NSP_B_CP] | cfg_q[`NSP_B_CPD];

  // Write protect: 00 all, 01 lower half, 10 first quarter, 11 none
  function wp_hit;
    input [1:0]  wrt;
    input [12:0] a;
    begin
      case (wrt)
        2'b00:   wp_hit = 1'b1;
        2'b01:   wp_hit = (a < 13'h1000);
        2'b10:   wp_hit = (a < 13'h0800);
        default: wp_hit = 1'b0;
      endcase
    end
  endfunction

  // Config-space decode: EEPROM at 0x7000 window, user IDs at 0x0000
  function is_ee;
    input [14:0] a;
    begin
      is_ee = (a[14:8] == `NSP_EE_ADR_HI);
    end
  endfunction

  function is_uid;
    input [14:0] a;
    begin
      is_uid = (a[14:2] == 13'h0000);
    end
  endfunction

  // Row source word: the addressed latch takes the data pair, so the
  // last word of a row need not be loaded on its own before programming
  function [13:0] row_src;
    input [4:0] i;
    begin
      row_src = (i == adr[4:0]) ? dat : latch_q[i];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait cycle; unmapped reads zero
  wire req  = I_WB_CYC & I_WB_STB & ~ack_q;
  wire wr   = req & I_WB_WE & I_WB_SEL[0];
  wire busy = (st_q != ST_IDLE);
  // Accesses are held off while the core is stalled
  assign O_WB_ACK    = ack_q;
  // Stall also spans the answer wait of a pointer read
  assign O_CPU_STALL = busy | ind_rd_q;
  assign O_DONE_IRQ  = ctrl_q[`NSP_B_DONE] & ctrl_q[`NSP_B_IRQEN];

  wire go_wr  = wr & (I_WB_ADR == `NSP_OFS_CTRL) & I_WB_DAT[`NSP_B_WR];
  wire go_rd  = wr & (I_WB_ADR == `NSP_OFS_CTRL) & I_WB_DAT[`NSP_B_RD];
  wire go_ind = req & ~I_WB_WE & (I_WB_ADR == `NSP_OFS_INDIRECT_ACCESS_PORT);
  // Unlock only counts if strobe follows AAh directly
  wire unlocked = (uk_q == UK_TWO) & I_WB_DAT[`NSP_B_WALLOW];
  wire key1  = (I_WB_ADR == `NSP_OFS_KEY) & (I_WB_DAT[7:0] == `NSP_KEY1);
  wire key2  = (I_WB_ADR == `NSP_OFS_KEY) & (I_WB_DAT[7:0] == `NSP_KEY2);
  // Flash target writable under the protect field
  wire fl_ok = ~regs & ~wp_hit(cfg_q[1:0], adr[12:0]);

  // Unlock tracker; a fresh 55h restarts it rather than dropping it
  always @* begin
    uk_d = uk_q;
    if (wr & ~busy) begin
      case (uk_q)
        UK_ONE:  uk_d = key2 ? UK_TWO : (key1 ? UK_ONE : UK_IDLE);
        default: uk_d = key1 ? UK_ONE : UK_IDLE;
      endcase
    end
  end

  // Read mux for the register file
  always @* begin
    rd_mux = 32'h0000_0000;
    case (I_WB_ADR)
      `NSP_OFS_CTRL: rd_mux[7:0] = ctrl_q;
      `NSP_OFS_ADRL: rd_mux[7:0] = adrl_q;
      `NSP_OFS_ADRH: rd_mux[6:0] = adrh_q;
      `NSP_OFS_DATL: rd_mux[7:0] = datl_q;
      `NSP_OFS_DATH: rd_mux[5:0] = dath_q;
      `NSP_OFS_CFG:  rd_mux[3:0] = cfg_q;
      `NSP_OFS_PTRL: rd_mux[7:0] = ptrl_q;
      `NSP_OFS_PTRH: rd_mux[7:0] = ptrh_q;
      `NSP_OFS_INDIRECT_ACCESS_PORT: rd_mux[13:0] = indirect_access_port_q;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data from a flop; the address is held until ack, so the
  // registered word is settled in the ack cycle
  always @(posedge I_REF_CLK) begin
    if (I_RESET)
      O_WB_DAT <= 32'h0000_0000;
    else
      O_WB_DAT <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers, unlock tracker and operation engine
  always @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      st_q <= ST_IDLE;
      uk_q <= UK_IDLE;
      ctrl_q <= 8'h00;
      adrl_q <= 8'h00;
      adrh_q <= 7'h00;
      datl_q <= 8'h00;
      dath_q <= 6'h00;
      cfg_q <= 4'h3;
      ptrl_q <= 8'h00;
      ptrh_q <= 8'h00;
      indirect_access_port_q <= 14'h0000;
      tmr_q <= 16'h0000;
      ack_q <= 1'b0;
      ind_rd_q <= 1'b0;
      for (k = 0; k < `NSP_ROW_WORDS; k = k + 1)
        latch_q[k] <= `NSP_BLANK;
    end else begin
      // Ack a request once idle; indirect reads ack after the stall
      ack_q <= req & ~busy & ~go_ind & ~go_rd & ~(go_wr & unlocked);
      if (ind_rd_q & ~busy) begin
        ack_q <= 1'b1;
        ind_rd_q <= 1'b0;
      end
      // Any write but the next key step or a 55h drops the tracker
      uk_q <= uk_d;
      if (wr & ~busy) begin
        case (I_WB_ADR)
          `NSP_OFS_CTRL: begin
            // WR and RD only set by software; done clears on write zero
            ctrl_q[`NSP_B_WALLOW] <= I_WB_DAT[`NSP_B_WALLOW];
            ctrl_q[`NSP_B_FREE]   <= I_WB_DAT[`NSP_B_FREE];
            ctrl_q[`NSP_B_LATCH_ONLY_SELECT]   <= I_WB_DAT[`NSP_B_LATCH_ONLY_SELECT];
            ctrl_q[`NSP_B_REGS]   <= I_WB_DAT[`NSP_B_REGS];
            ctrl_q[`NSP_B_IRQEN]  <= I_WB_DAT[`NSP_B_IRQEN];
            ctrl_q[`NSP_B_DONE]   <= ctrl_q[`NSP_B_DONE]
                                     & I_WB_DAT[`NSP_B_DONE];
          end
          `NSP_OFS_ADRL: adrl_q <= I_WB_DAT[7:0];
          `NSP_OFS_ADRH: adrh_q <= I_WB_DAT[6:0];
          `NSP_OFS_DATL: datl_q <= I_WB_DAT[7:0];
          `NSP_OFS_DATH: dath_q <= I_WB_DAT[5:0];
          `NSP_OFS_CFG:  cfg_q  <= I_WB_DAT[3:0];
          `NSP_OFS_PTRL: ptrl_q <= I_WB_DAT[7:0];
          `NSP_OFS_PTRH: ptrh_q <= I_WB_DAT[7:0];
          // Writes through the pointer port are dropped
          `NSP_OFS_INDIRECT_ACCESS_PORT: ;
          default: ;
        endcase
        if (go_rd && !cp) begin
          ctrl_q[`NSP_B_RD] <= 1'b1;
          st_q <= ST_READ;
        end else if (go_rd) begin
          // Refused read still answers, else the bus would hang
          ack_q <= 1'b1;
        end
        // Code protect blocks the register path entirely
        if (go_wr && unlocked && !cp) begin
          ctrl_q[`NSP_B_WR] <= 1'b1;
          st_q <= ST_PROG;
          tmr_q <= PROG_CYC[15:0];
        end else if (go_wr) begin
          ack_q <= 1'b1;
        end
      end
      // One pointer read per request; no restart while its ack waits
      if (go_ind & ~busy & ~ind_rd_q) begin
        ind_rd_q <= 1'b1;
        st_q <= ST_IND;
      end
      case (st_q)
        ST_IDLE: ;
        // Single-cycle array read; data readable next cycle
        ST_READ: begin
          if (!regs)
            {dath_q, datl_q} <= flash_q[adr[12:0]];
          else if (is_ee(adr))
            {dath_q, datl_q} <= {6'h00, ee_q[adr[7:0]]};
          else if (is_uid(adr))
            {dath_q, datl_q} <= uid_q[adr[1:0]];
          else
            {dath_q, datl_q} <= 14'h0000;
          ctrl_q[`NSP_B_RD] <= 1'b0;
          ack_q <= 1'b1;
          st_q <= ST_IDLE;
        end
        // Pointer read of one word, then release the stall; code
        // protect does not reach this path
        ST_IND: begin
          if (ptrh_q == `NSP_EE_PTR_HI)
            indirect_access_port_q <= {6'h00, ee_q[ptrl_q]};
          else
            indirect_access_port_q <= flash_q[{ptrh_q[4:0], ptrl_q}];
          st_q <= ST_IDLE;
        end
        // Timed program or erase; latch loads also take the timer
        ST_PROG: begin
          if (tmr_q > 16'h0001) begin
            tmr_q <= tmr_q - 16'h0001;
          end else begin
            if (ctrl_q[`NSP_B_LATCH_ONLY_SELECT] && !ctrl_q[`NSP_B_FREE]) begin
              latch_q[adr[4:0]] <= dat;
            end else if (ctrl_q[`NSP_B_FREE]) begin
              // Row erase only; no bulk erase here
              if (regs && is_uid(adr)) begin
                for (k = 0; k < `NSP_UID_WORDS; k = k + 1)
                  uid_q[k] <= `NSP_BLANK;
              end else if (fl_ok) begin
                for (k = 0; k < `NSP_ROW_WORDS; k = k + 1)
                  flash_q[{adr[12:5], k[4:0]}] <= `NSP_BLANK;
              end
            end else begin
              if (regs && is_ee(adr))
                ee_q[adr[7:0]] <= datl_q;
              else if (regs && is_uid(adr))
                for (k = 0; k < `NSP_UID_WORDS; k = k + 1)
                  uid_q[k] <= uid_q[k] & row_src(k[4:0]);
              else if (fl_ok)
                for (k = 0; k < `NSP_ROW_WORDS; k = k + 1)
                  flash_q[{adr[12:5], k[4:0]}] <=
                    flash_q[{adr[12:5], k[4:0]}] & row_src(k[4:0]);
              for (k = 0; k < `NSP_ROW_WORDS; k = k + 1)
                latch_q[k] <= `NSP_BLANK;
            end
            ctrl_q[`NSP_B_WR] <= 1'b0;
            ctrl_q[`NSP_B_DONE] <= 1'b1;
            ack_q <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule // nsp_ctrl
`default_nettype wire

// >>> logic/nsp_map.vh
`ifndef NSP_MAP_VH
`define NSP_MAP_VH
// Register byte offsets (one 32-bit word each)
`define NSP_OFS_CTRL      8'h00
`define NSP_OFS_KEY       8'h04
`define NSP_OFS_ADRL      8'h08
`define NSP_OFS_ADRH      8'h0C
`define NSP_OFS_DATL      8'h10
`define NSP_OFS_DATH      8'h14
`define NSP_OFS_CFG       8'h18
`define NSP_OFS_PTRL      8'h1C
`define NSP_OFS_PTRH      8'h20
`define NSP_OFS_INDIRECT_ACCESS_PORT      8'h24
// Control register bit positions
`define NSP_B_RD          0
`define NSP_B_WR          1
`define NSP_B_WALLOW      2
`define NSP_B_FREE        3
`define NSP_B_LATCH_ONLY_SELECT        4
`define NSP_B_DONE        5
`define NSP_B_REGS        6
`define NSP_B_IRQEN       7
// Config register bit positions
`define NSP_B_WRT_LO      0
`define NSP_B_CP          2
`define NSP_B_CPD         3
// Unlock keys
`define NSP_KEY1          8'h55
`define NSP_KEY2          8'hAA
`define NSP_EE_PTR_HI     8'h70
`define NSP_EE_ADR_HI     7'h70
`define NSP_BLANK         14'h3FFF
`define NSP_FLASH_WORDS   8192
`define NSP_ROW_WORDS     32
`define NSP_UID_WORDS     4
// Program / erase time
`define NSP_T_PROG_NS     2000
`define NSP_CLK_NS        5
`define NSP_PROG_CYC      ((`NSP_T_PROG_NS + `NSP_CLK_NS - 1) / `NSP_CLK_NS)
`endif

// >>> verification/nsp_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "nsp_map.vh"
module nsp_ctrl_sva #(
  parameter int PROG_CYC = 400
) (
  input wire logic        I_REF_CLK,
  input wire logic        I_RESET,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [7:0]  I_WB_ADR,
  input wire logic [3:0]  I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        O_WB_ACK,
  input wire logic        O_CPU_STALL,
  input wire logic        O_DONE_IRQ
);
  logic [1:0] unl_q;
  logic [3:0] cfg_q;
  logic       take;
  logic       wctl;
  logic       cp_on;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);
  // Request taken only when idle; ack cycle excluded
  assign take = I_WB_CYC && I_WB_STB && !O_WB_ACK && !O_CPU_STALL;
  assign wctl = take && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == `NSP_OFS_CTRL;
  assign cp_on = cfg_q[`NSP_B_CP] | cfg_q[`NSP_B_CPD];
  // Shadow unlock progress and config from acked writes
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      unl_q <= 2'h0;
      cfg_q <= 4'h3;
    end else if (O_WB_ACK && I_WB_CYC && I_WB_WE && I_WB_SEL[0]) begin
      if (I_WB_ADR == `NSP_OFS_KEY && I_WB_DAT[7:0] == `NSP_KEY1)
        unl_q <= 2'h1;
      else if (I_WB_ADR == `NSP_OFS_KEY && I_WB_DAT[7:0] == `NSP_KEY2 &&
               unl_q == 2'h1)
        unl_q <= 2'h2;
      else
        unl_q <= 2'h0;
      if (I_WB_ADR == `NSP_OFS_CFG)
        cfg_q <= I_WB_DAT[3:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_busy;
    O_CPU_STALL [*3];
  endsequence
  sequence s_rd_walk;
    O_CPU_STALL && !O_WB_ACK ##1 O_WB_ACK && !O_CPU_STALL;
  endsequence
  sequence s_unl_wr;
    wctl && I_WB_DAT[`NSP_B_WR] && I_WB_DAT[`NSP_B_WALLOW] &&
    !I_WB_DAT[`NSP_B_REGS] && unl_q == 2'h2 && cfg_q == 4'h3;
  endsequence
  property p_ack_pulse;
    O_WB_ACK |=> !O_WB_ACK;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack too long");
  property p_ack_cause;
    $rose(O_WB_ACK) |-> $past(I_WB_CYC && I_WB_STB);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack unasked");
  property p_rd_walk;
    wctl && I_WB_DAT[`NSP_B_RD] && !I_WB_DAT[`NSP_B_WR] &&
      !cp_on |=> s_rd_walk;
  endproperty
  a_rd_walk: assert property (p_rd_walk)
    else $error("read walk bad");
  property p_cp_rd;
    wctl && I_WB_DAT[`NSP_B_RD] && cp_on
      |=> O_WB_ACK && !O_CPU_STALL;
  endproperty
  a_cp_rd: assert property (p_cp_rd)
    else $error("protected read ran");
  property p_ptr_rd;
    take && !I_WB_WE && I_WB_ADR == `NSP_OFS_INDIRECT_ACCESS_PORT
      |=> O_CPU_STALL [*2] ##1 O_WB_ACK;
  endproperty
  a_ptr_rd: assert property (p_ptr_rd)
    else $error("pointer read bad");
  property p_prog;
    s_unl_wr |=> s_busy ##[1:PROG_CYC] O_WB_ACK;
  endproperty
  a_prog: assert property (p_prog)
    else $error("program op bad");
  property p_locked;
    wctl && I_WB_DAT[`NSP_B_WR] && unl_q != 2'h2
      |=> O_WB_ACK && !O_CPU_STALL;
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked write ran");
  property p_key;
    take && I_WB_WE && I_WB_ADR == `NSP_OFS_KEY
      |=> O_WB_ACK && !O_CPU_STALL;
  endproperty
  a_key: assert property (p_key)
    else $error("key write slow");
  property p_irq;
    $rose(O_DONE_IRQ) |-> O_WB_ACK || $past(O_WB_ACK);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq without cause");
endmodule // nsp_ctrl_sva
bind nsp_ctrl nsp_ctrl_sva #(.PROG_CYC(PROG_CYC)) u_sva (
  .I_REF_CLK(I_REF_CLK), .I_RESET(I_RESET), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT),
  .O_WB_ACK(O_WB_ACK), .O_CPU_STALL(O_CPU_STALL), .O_DONE_IRQ(O_DONE_IRQ));
`default_nettype wire

// >>> verification/nsp_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "nsp_map.vh"
module nsp_cpu_model (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_dat,
  output var  logic        o_cyc,
  output var  logic        o_stb,
  output var  logic        o_we,
  output var  logic [7:0]  o_adr,
  output var  logic [3:0]  o_sel,
  output var  logic [31:0] o_dat
);
  // Bus idle from time zero
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we = 1'b0;
    o_adr = 8'h00;
    o_sel = 4'h0;
    o_dat = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////
  // One classic cycle; held until ack, bounded so a hang ends the run
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] wd, input logic [3:0] s,
                      output logic [31:0] rd);
    int n;
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we <= w;
    o_adr <= a;
    o_sel <= s;
    o_dat <= {24'h00_0000, wd};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ack !== 1'b1 && n < 300);
    rd = i_dat;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    if (i_ack !== 1'b1) begin
      test_nvm_self_program_control.bad_count++;
      test_nvm_self_program_control.give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, 4'h1, x);
  endtask
  // Write on chosen lanes; with lane 0 clear nothing may change
  task automatic wr_sel(input logic [7:0] a, input logic [7:0] d,
                        input logic [3:0] s);
    logic [31:0] x;
    xfer(1'b1, a, d, s, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 8'h00, 4'hF, d);
  endtask
  // Keys back to back; nothing may slip in, as if interrupts were off
  task automatic unlock(input logic [7:0] ctrl);
    wr(`NSP_OFS_KEY, `NSP_KEY1);
    wr(`NSP_OFS_KEY, `NSP_KEY2);
    wr(`NSP_OFS_CTRL, ctrl | 8'h02);
  endtask
endmodule // nsp_cpu_model
`default_nettype wire

// >>> verification/test_nvm_self_program_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "nsp_map.vh"
module test_nvm_self_program_control;
  logic        clk;
  logic        rst;
  logic        cyc, stb, we, ack, stall, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, d;
  int          bad_count;
  int          num_checks;
  // 200 MHz reference
  always #2.5 clk = ~clk;
  nsp_ctrl #(.PROG_CYC(4)) dut (.I_REF_CLK(clk), .I_RESET(rst),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .O_CPU_STALL(stall), .O_DONE_IRQ(irq));
  nsp_cpu_model cpu (.i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc),
    .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic setadr(input logic [15:0] a);
    cpu.wr(`NSP_OFS_ADRL, a[7:0]);
    cpu.wr(`NSP_OFS_ADRH, a[15:8]);
  endtask
  // Register-path flash read, word split across the data pair
  task automatic fchk(input logic [15:0] a, input logic [13:0] e);
    setadr(a);
    cpu.wr(`NSP_OFS_CTRL, 8'h01);
    cpu.rd(`NSP_OFS_DATL, d);
    check(d, {24'h00_0000, e[7:0]});
    cpu.rd(`NSP_OFS_DATH, d);
    check(d, {26'h000_0000, e[13:8]});
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence; flash is undefined until the row is erased
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    bad_count = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cpu.rd(`NSP_OFS_CFG, d);
    check(d, 32'h0000_0003);
    setadr(16'h0040);
    cpu.unlock(8'h0C);
    cpu.wr(`NSP_OFS_DATL, 8'h34);
    cpu.wr(`NSP_OFS_DATH, 8'h12);
    cpu.unlock(8'h14);
    setadr(16'h0041);
    cpu.wr(`NSP_OFS_DATL, 8'hBC);
    cpu.wr(`NSP_OFS_DATH, 8'h2A);
    cpu.unlock(8'h04);
    cpu.rd(`NSP_OFS_CTRL, d);
    check(d & 32'h0000_0022, 32'h0000_0020);
    fchk(16'h0040, 14'h1234);
    fchk(16'h0041, 14'h2ABC);
    fchk(16'h0042, 14'h3FFF);
    // Fully protected erase must leave the row alone
    cpu.wr(`NSP_OFS_CFG, 8'h00);
    cpu.wr(`NSP_OFS_CTRL, 8'h00);
    setadr(16'h0040);
    cpu.unlock(8'h0C);
    cpu.rd(`NSP_OFS_CTRL, d);
    check(d & 32'h0000_0022, 32'h0000_0020);
    fchk(16'h0040, 14'h1234);
    cpu.wr(`NSP_OFS_CFG, 8'h03);
    // Byte write, then pointer read; pointer writes are dropped
    cpu.wr(`NSP_OFS_CTRL, 8'h80);
    check({31'h0, irq}, 32'h0000_0000);
    setadr(16'h7005);
    cpu.wr(`NSP_OFS_DATL, 8'h5A);
    cpu.unlock(8'hC4);
    cpu.wr(`NSP_OFS_PTRH, `NSP_EE_PTR_HI);
    cpu.wr(`NSP_OFS_PTRL, 8'h05);
    check({31'h0, irq}, 32'h0000_0001);
    cpu.wr(`NSP_OFS_INDIRECT_ACCESS_PORT, 8'h11);
    cpu.rd(`NSP_OFS_INDIRECT_ACCESS_PORT, d);
    check(d & 32'h0000_00FF, 32'h0000_005A);
    // Broken key order must start nothing
    cpu.wr(`NSP_OFS_DATL, 8'hA5);
    cpu.wr(`NSP_OFS_KEY, `NSP_KEY1);
    cpu.wr(`NSP_OFS_ADRL, 8'h05);
    cpu.wr(`NSP_OFS_KEY, `NSP_KEY2);
    cpu.wr(`NSP_OFS_CTRL, 8'h46);
    cpu.rd(`NSP_OFS_INDIRECT_ACCESS_PORT, d);
    check(d & 32'h0000_00FF, 32'h0000_005A);
    // Protected read leaves the data pair as written
    cpu.wr(`NSP_OFS_DATL, 8'h77);
    cpu.wr_sel(`NSP_OFS_DATL, 8'h99, 4'hE);
    cpu.wr(`NSP_OFS_CFG, 8'h07);
    cpu.wr(`NSP_OFS_CTRL, 8'h01);
    cpu.rd(`NSP_OFS_DATL, d);
    check(d, 32'h0000_0077);
    // Pointer reads still work under code protect
    cpu.rd(`NSP_OFS_INDIRECT_ACCESS_PORT, d);
    check(d & 32'h0000_00FF, 32'h0000_005A);
    cpu.rd(8'h3C, d);
    check(d, 32'h0000_0000);
    give_verdict();
  end
endmodule // test_nvm_self_program_control
`default_nettype wire
